// ===== core/scf_buf2.sv
// Two-entry valid/ready buffer, head always in the first slot
`timescale 1ns/10ps

module scf_buf2
#(
  parameter int W = 32
)
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  logic         v1;
  logic [W-1:0] d1;
  logic         push;
  logic         pop;

  if (W < 1)
  begin : g_bad_w
    $error("buffer width must be at least one");
  end

  // Ready is not offered while both slots hold words, even on a pop
  assign in_ready = !v1;
  assign push     = in_valid && !v1;
  assign pop      = out_valid && out_ready;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      out_valid <= 1'h0;
      v1        <= 1'h0;
      out_data  <= '0;
      d1        <= '0;
    end
    else if (push && (pop || !out_valid))
    begin
      out_valid <= 1'h1;
      out_data  <= in_data;
    end
    else if (push)
    begin
      v1 <= 1'h1;
      d1 <= in_data;
    end
    else if (pop)
    begin
      out_valid <= v1;
      out_data  <= d1;
      v1        <= 1'h0;
    end
  end
endmodule

// ===== core/scf_cfg.svh
// Default sizes and limits for the stream channel
`ifndef SCF_CFG_SVH
`define SCF_CFG_SVH

`define SCF_DATA_W_DEF 32
`define SCF_DEPTH_DEF 1
`define SCF_DEPTH_MAX 1024

`endif

// ===== core/scf_channel.sv
// Channel storage end: shift-register FIFO served over the link
`timescale 1ns/10ps
`include "scf_cfg.svh"

module scf_channel
#(
  parameter int                      DW    = `SCF_DATA_W_DEF,
  parameter int                      DEPTH = `SCF_DEPTH_DEF,
  parameter scf_pkg::scf_port_mode_t MODE  = scf_pkg::scf_fifo_style_port,
  parameter scf_pkg::scf_scope_t     SCOPE = scf_pkg::scf_local,
  parameter int                      LW    = $clog2(DEPTH + 1)
)
(
  // Clock and reset
  input  wire logic     mclk,
  input  wire logic     rst,
  // Link to the producer and consumer end
  scf_link_if.chan      lnk,
  // Occupancy and protocol observation
  output logic [LW-1:0] fill_level,
  output logic          wr_refused,
  output logic          rd_refused
);
  localparam bit            IS_HS    = (MODE == scf_pkg::scf_handshake_port);
  localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);

  logic [DW-1:0] mem [DEPTH];
  logic [LW-1:0] count;
  logic [LW-1:0] next_count;
  logic [LW-1:0] wr_slot;
  logic [DW-1:0] hs_data;
  logic          has_room;
  logic          has_head;
  logic          push;
  logic          pop;
  logic          not_full;
  logic          not_empty;
  logic          wr_ack;
  logic          rd_ack;

  // Parameter checks

  if (DEPTH < 1 || DEPTH > `SCF_DEPTH_MAX)
  begin : g_bad_depth
    $error("channel depth out of range");
  end

  if (LW < $clog2(DEPTH + 1))
  begin : g_bad_lw
    $error("level width too narrow for depth");
  end

  if (DW < 1)
  begin : g_bad_dw
    $error("data width must be at least one");
  end

  // A one-sided global channel is a boundary port with no storage, so
  // it must never reach this module; local and two-sided ones do.
  if (SCOPE == scf_pkg::scf_global_one_sided)
  begin : g_bad_scope
    $error("one-sided global channel must be a boundary port");
  end

  // Occupancy decode

  assign has_room = (count != FULL_LVL);
  assign has_head = (count != '0);

  // On the handshake port an acknowledge in flight blocks a second
  // transfer, since the partner drops its request one cycle later.
  assign push = lnk.wr_en && has_room && !(IS_HS && wr_ack);
  assign pop  = lnk.rd_en && has_head && !(IS_HS && rd_ack);

  // A write that meets a pop lands one slot lower, behind the shift
  assign wr_slot = pop ? LW'(count - 1'h1) : count;

  always_comb
  begin
    next_count = count;
    case ({push, pop})
      2'h2:    next_count = LW'(count + 1'h1);
      2'h1:    next_count = LW'(count - 1'h1);
      default: next_count = count;
    endcase
  end

  // Storage: the head always sits in entry 0, so it reads from a flop

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    localparam logic [LW-1:0] IDX = LW'(i);

    logic [DW-1:0] shifted;
    logic          take;

    if (i < DEPTH - 1)
    begin : g_mid
      assign shifted = mem[i + 1];
    end
    else
    begin : g_tail
      assign shifted = mem[i];
    end

    assign take = push && (wr_slot == IDX);

    always_ff @(posedge mclk)
    begin
      if (rst)
        mem[i] <= '0;
      else if (take)
        mem[i] <= lnk.wr_data;
      else if (pop)
        mem[i] <= shifted;
    end
  end

  // Level and flags

  always_ff @(posedge mclk)
  begin
    if (rst)
      count <= '0;
    else
      count <= next_count;
  end

  // Flags are registered from the next level, so they change with the
  // acknowledge of the transfer that moved them.
  // Status is not offered on the handshake port.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      not_full  <= !IS_HS;
      not_empty <= 1'h0;
    end
    else
    begin
      not_full  <= !IS_HS && (next_count != FULL_LVL);
      not_empty <= !IS_HS && (next_count != '0);
    end
  end

  // Acknowledges

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_ack <= 1'h0;
      rd_ack <= 1'h0;
    end
    else
    begin
      wr_ack <= push;
      rd_ack <= pop;
    end
  end

  // Handshake read data is the popped head, held until the next pop
  always_ff @(posedge mclk)
  begin
    if (rst)
      hs_data <= '0;
    else if (pop)
      hs_data <= mem[0];
  end

  // Protocol observation

  // A strobe against a closed flag is dropped without effect. On the
  // handshake port a waiting request is a normal stall, not a refusal.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_refused <= 1'h0;
      rd_refused <= 1'h0;
    end
    else
    begin
      wr_refused <= !IS_HS && lnk.wr_en && !has_room;
      rd_refused <= !IS_HS && lnk.rd_en && !has_head;
    end
  end

  // Link outputs

  assign fill_level    = count;
  assign lnk.not_full  = not_full;
  assign lnk.not_empty = not_empty;
  assign lnk.wr_ack    = wr_ack;
  assign lnk.rd_ack    = rd_ack;

  // FIFO-style port shows the head ahead of the strobe
  assign lnk.rd_data   = IS_HS ? hs_data : mem[0];
endmodule

// ===== core/scf_link_if.sv
// Link between the channel storage end and its producer/consumer end
`timescale 1ns/10ps
`include "scf_cfg.svh"

interface scf_link_if
#(
  parameter int DW = `SCF_DATA_W_DEF
);
  // Write side
  logic          wr_en;
  logic [DW-1:0] wr_data;
  logic          not_full;
  logic          wr_ack;
  // Read side
  logic          rd_en;
  logic [DW-1:0] rd_data;
  logic          not_empty;
  logic          rd_ack;

  // One modport per party, so a link has one channel end and one user end that both writes and reads
  modport chan
  (
    input  wr_en, wr_data, rd_en,
    output not_full, wr_ack, rd_data, not_empty, rd_ack
  );

  modport user
  (
    output wr_en, wr_data, rd_en,
    input  not_full, wr_ack, rd_data, not_empty, rd_ack
  );
endinterface

// ===== core/scf_pkg.sv
// Types shared by both ends of the stream channel
package scf_pkg;

  typedef enum logic
  {
    scf_fifo_style_port = 1'h0,
    scf_handshake_port  = 1'h1
  } scf_port_mode_t;

  typedef enum logic [1:0]
  {
    scf_local            = 2'h0,
    scf_global_rw        = 2'h1,
    scf_global_one_sided = 2'h2
  } scf_scope_t;

  typedef enum logic [3:0]
  {
    scf_idle   = 4'h1,
    scf_room   = 4'h2,
    scf_strobe = 4'h4,
    scf_ack    = 4'h8
  } scf_xfer_state_t;

endpackage

// ===== core/scf_user.sv
// Producer/consumer end: turns user requests into link transfers
`timescale 1ns/10ps
`include "scf_cfg.svh"

module scf_user
#(
  parameter int                      DW    = `SCF_DATA_W_DEF,
  parameter scf_pkg::scf_port_mode_t MODE  = scf_pkg::scf_fifo_style_port,
  parameter bit                      AXIS  = 1'h0
)
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // Link to the channel
  scf_link_if.user           lnk,
  // Producer requests
  input  wire logic          put_req,
  input  wire logic          put_try,
  input  wire logic [DW-1:0] put_data,
  output logic               put_busy,
  output logic               put_done,
  output logic               put_ok,
  // Consumer requests
  input  wire logic          get_req,
  input  wire logic          get_try,
  output logic               get_busy,
  output logic               get_done,
  output logic               get_ok,
  // Consumer data
  output logic               get_valid,
  output logic [DW-1:0]      get_data,
  input  wire logic          get_ready,
  // Status queries
  output logic               chan_full,
  output logic               chan_empty
);
  localparam bit IS_HS  = (MODE == scf_pkg::scf_handshake_port);
  localparam bit NO_TRY = IS_HS || AXIS;

  scf_pkg::scf_xfer_state_t st      [2];
  scf_pkg::scf_xfer_state_t next_st [2];
  logic [1:0]               req_v;
  logic [1:0]               try_v;
  logic [1:0]               ack_v;
  logic [1:0]               avail_v;
  logic [1:0]               refuse_v;
  logic [1:0]               en_q;
  logic [1:0]               done_q;
  logic [1:0]               ok_q;
  logic [1:0]               busy_q;
  logic [DW-1:0]            wr_data;
  logic                     buf_in_valid;
  logic                     buf_in_ready;

  if (DW < 1)
  begin : g_bad_dw
    $error("data width must be at least one");
  end

  // Side 0 writes, side 1 reads
  assign req_v = {get_req, put_req};
  assign try_v = {get_try, put_try};
  assign ack_v = {lnk.rd_ack, lnk.wr_ack};

  // A read is issued only when the buffer can take its word
  assign avail_v[0] = IS_HS ? 1'h1 : lnk.not_full;
  assign avail_v[1] = buf_in_ready && (IS_HS || lnk.not_empty);

  assign refuse_v = try_v & ({2{NO_TRY}} | ~avail_v);

  for (genvar s = 0; s < 2; s++)
  begin : g_side
    always_comb
    begin
      next_st[s] = st[s];
      case (st[s])
        scf_pkg::scf_idle:
        begin
          if (req_v[s] && !refuse_v[s])
            next_st[s] = avail_v[s] ? scf_pkg::scf_strobe : scf_pkg::scf_room;
        end
        scf_pkg::scf_room:
        begin
          if (avail_v[s])
            next_st[s] = scf_pkg::scf_strobe;
        end
        scf_pkg::scf_strobe:
        begin
          // Handshake holds the request until the channel acknowledges
          if (!IS_HS)
            next_st[s] = scf_pkg::scf_ack;
          else if (ack_v[s])
            next_st[s] = scf_pkg::scf_idle;
        end
        scf_pkg::scf_ack:
        begin
          if (ack_v[s])
            next_st[s] = scf_pkg::scf_idle;
        end
        default:
          next_st[s] = scf_pkg::scf_idle;
      endcase
    end

    always_ff @(posedge mclk)
    begin
      if (rst)
      begin
        st[s]     <= scf_pkg::scf_idle;
        en_q[s]   <= 1'h0;
        done_q[s] <= 1'h0;
        ok_q[s]   <= 1'h0;
        busy_q[s] <= 1'h0;
      end
      else
      begin
        st[s]     <= next_st[s];
        en_q[s]   <= (next_st[s] == scf_pkg::scf_strobe);
        done_q[s] <= ack_v[s] || (st[s] == scf_pkg::scf_idle && req_v[s] && refuse_v[s]);
        ok_q[s]   <= ack_v[s];
        busy_q[s] <= (next_st[s] != scf_pkg::scf_idle);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      wr_data <= '0;
    else if (st[0] == scf_pkg::scf_idle && put_req && !refuse_v[0])
      wr_data <= put_data;
  end

  // Flags lag the link by one cycle; hidden on the handshake port
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      chan_full  <= 1'h0;
      chan_empty <= 1'h0;
    end
    else
    begin
      chan_full  <= !IS_HS && !lnk.not_full;
      chan_empty <= !IS_HS && !lnk.not_empty;
    end
  end

  assign lnk.wr_en   = en_q[0];
  assign lnk.rd_en   = en_q[1];
  assign lnk.wr_data = wr_data;
  assign put_busy    = busy_q[0];
  assign put_done    = done_q[0];
  assign put_ok      = ok_q[0];
  assign get_busy    = busy_q[1];
  assign get_done    = done_q[1];
  assign get_ok      = ok_q[1];

  // Head word is on the link during a strobe, or with the acknowledge
  assign buf_in_valid = IS_HS ? lnk.rd_ack : lnk.rd_en;

  scf_buf2
  #(
    .W (DW)
  )
  u_buf
  (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (buf_in_valid),
    .in_data   (lnk.rd_data),
    .in_ready  (buf_in_ready),
    .out_valid (get_valid),
    .out_data  (get_data),
    .out_ready (get_ready)
  );
endmodule

// ===== tb/scf_props.sv
// Assertions on the link between the channel storage end and its user end
`timescale 1ns/10ps

module scf_props
#(
  parameter int DW    = 32,
  parameter int DEPTH = 2
)
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic          not_full,
  input  wire logic          wr_ack,
  // Read side
  input  wire logic          rd_en,
  input  wire logic [DW-1:0] rd_data,
  input  wire logic          not_empty,
  input  wire logic          rd_ack
);
  logic [10:0] cnt;
  logic [10:0] cnt_now;

  // Occupancy rebuilt from the acks, independent of the design's own count
  assign cnt_now = cnt + 11'(wr_ack) - 11'(rd_ack);

  always_ff @(posedge mclk)
  begin
    if (rst)
      cnt <= 11'h000;
    else
      cnt <= cnt_now;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_wr_take;
    wr_en && not_full;
  endsequence
  sequence s_wr_ack;
    ##1 wr_ack ##1 !wr_ack;
  endsequence
  sequence s_rd_take;
    rd_en && not_empty;
  endsequence
  sequence s_rd_ack;
    ##1 rd_ack ##1 !rd_ack;
  endsequence

  property p_write_step;
    s_wr_take |-> s_wr_ack;
  endproperty
  property p_read_step;
    s_rd_take |-> s_rd_ack;
  endproperty
  property p_wr_cause;
    wr_ack |-> $past(wr_en) && $past(not_full);
  endproperty
  property p_rd_cause;
    rd_ack |-> $past(rd_en) && $past(not_empty);
  endproperty
  property p_full_flag;
    not_full == (cnt_now != 11'(DEPTH));
  endproperty
  property p_empty_flag;
    not_empty == (cnt_now != 11'h000);
  endproperty
  property p_depth;
    cnt_now <= 11'(DEPTH);
  endproperty
  // Head may move with or one cycle after an ack, never otherwise
  property p_head_hold;
    !(wr_ack || rd_ack || $past(wr_ack) || $past(rd_ack)) |-> $stable(rd_data);
  endproperty

  a_write_step: assert property (p_write_step)
    else $error("write strobe not acknowledged once");
  a_read_step: assert property (p_read_step)
    else $error("read strobe not acknowledged once");
  a_wr_cause: assert property (p_wr_cause)
    else $error("write ack without an open strobe");
  a_rd_cause: assert property (p_rd_cause)
    else $error("read ack without an open strobe");
  a_full_flag: assert property (p_full_flag)
    else $error("not_full disagrees with occupancy");
  a_empty_flag: assert property (p_empty_flag)
    else $error("not_empty disagrees with occupancy");
  a_depth: assert property (p_depth)
    else $error("occupancy above depth");
  a_head_hold: assert property (p_head_hold)
    else $error("head word changed without a transfer");
endmodule

// ===== tb/stream_channel_fifo_tb.sv
// Self-checking bench: user end and channel end joined by a link
`timescale 1ns/10ps

module stream_channel_fifo_tb;
  localparam int D = 2;
  logic        mclk       = 1'h0;
  logic        rst        = 1'h1;
  logic        put_req    = 1'h0;
  logic        put_try    = 1'h0;
  logic [31:0] put_data   = 32'h0;
  logic        get_req    = 1'h0;
  logic        get_try    = 1'h0;
  logic        get_ready  = 1'h0;
  logic        put_busy;
  logic        put_done;
  logic        put_ok;
  logic        get_busy;
  logic        get_done;
  logic        get_ok;
  logic        get_valid;
  logic [31:0] get_data;
  logic        chan_full;
  logic        chan_empty;
  logic [1:0]  fill_level;
  logic        wr_refused2;
  logic        rd_refused2;
  logic        h_put_req   = 1'h0;
  logic        h_get_req   = 1'h0;
  logic        h_try       = 1'h0;
  logic        h_get_ready = 1'h0;
  logic        a_req       = 1'h0;
  logic        h_put_busy;
  logic        h_put_done;
  logic        h_put_ok;
  logic        h_get_done;
  logic        h_get_ok;
  logic        h_get_valid;
  logic [31:0] h_get_data;
  logic        h_chan_full;
  logic        h_chan_empty;
  logic        a_put_done;
  logic        a_put_ok;
  logic        a_get_done;
  logic        a_get_ok;
  int          mismatches   = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  scf_link_if lnk ();
  scf_link_if lnk2 ();
  scf_link_if lnk3 ();
  scf_link_if lnk4 ();

  scf_user i_scf_user (.mclk(mclk), .rst(rst), .lnk(lnk), .put_req(put_req),
    .put_try(put_try), .put_data(put_data), .put_busy(put_busy), .put_done(put_done),
    .put_ok(put_ok), .get_req(get_req), .get_try(get_try), .get_busy(get_busy),
    .get_done(get_done), .get_ok(get_ok), .get_valid(get_valid), .get_data(get_data),
    .get_ready(get_ready), .chan_full(chan_full), .chan_empty(chan_empty));
  scf_channel #(.DEPTH(D)) i_scf_channel (.mclk(mclk), .rst(rst), .lnk(lnk),
    .fill_level(fill_level), .wr_refused(), .rd_refused());
  // Second channel, default depth, strobed directly to break the flag rules
  scf_channel #(.SCOPE(scf_pkg::scf_global_rw)) i_scf_channel_2 (.mclk(mclk), .rst(rst),
    .lnk(lnk2), .fill_level(), .wr_refused(wr_refused2), .rd_refused(rd_refused2));
  // Handshake pair, depth one: status hidden, requests held until acknowledged
  scf_user #(.MODE(scf_pkg::scf_handshake_port)) i_scf_user_hs (.mclk(mclk), .rst(rst),
    .lnk(lnk3), .put_req(h_put_req), .put_try(h_try), .put_data(put_data),
    .put_busy(h_put_busy), .put_done(h_put_done), .put_ok(h_put_ok), .get_req(h_get_req),
    .get_try(h_try), .get_busy(), .get_done(h_get_done), .get_ok(h_get_ok),
    .get_valid(h_get_valid), .get_data(h_get_data), .get_ready(h_get_ready),
    .chan_full(h_chan_full), .chan_empty(h_chan_empty));
  scf_channel #(.MODE(scf_pkg::scf_handshake_port)) i_scf_channel_hs (.mclk(mclk), .rst(rst),
    .lnk(lnk3), .fill_level(), .wr_refused(), .rd_refused());
  // Stream-resource user: every try access is refused, even with room
  scf_user #(.AXIS(1'h1)) i_scf_user_ax (.mclk(mclk), .rst(rst), .lnk(lnk4), .put_req(a_req),
    .put_try(h_try), .put_data(put_data), .put_busy(), .put_done(a_put_done),
    .put_ok(a_put_ok), .get_req(a_req), .get_try(h_try), .get_busy(), .get_done(a_get_done),
    .get_ok(a_get_ok), .get_valid(), .get_data(), .get_ready(h_get_ready), .chan_full(),
    .chan_empty());
  scf_channel i_scf_channel_ax (.mclk(mclk), .rst(rst), .lnk(lnk4), .fill_level(),
    .wr_refused(), .rd_refused());
  scf_props #(.DW(32), .DEPTH(D)) i_scf_props (.mclk(mclk), .rst(rst),
    .wr_en(lnk.wr_en), .wr_data(lnk.wr_data), .not_full(lnk.not_full),
    .wr_ack(lnk.wr_ack), .rd_en(lnk.rd_en), .rd_data(lnk.rd_data),
    .not_empty(lnk.not_empty), .rd_ack(lnk.rd_ack));

  always #2.5 mclk = ~mclk;

  task automatic finish_test;
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // One user request; wr picks the producer or the consumer port
  task automatic xfer(input logic wr, input logic t, input logic [31:0] d, input logic ok);
    int n;
    @(negedge mclk);
    if (wr)
    begin
      put_req = 1'h1;
      put_try = t;
      put_data = d;
    end
    else
    begin
      get_req = 1'h1;
      get_try = t;
    end
    @(negedge mclk);
    put_req = put_req & ~wr;
    get_req = get_req & wr;
    n = 0;
    while ((wr ? put_done : get_done) !== 1'h1 && n < 99)
    begin
      @(negedge mclk);
      n++;
    end
    chk_bit("done", 1'h1, wr ? put_done : get_done);
    chk_bit("ok", ok, wr ? put_ok : get_ok);
  endtask

  // One request on the handshake pair
  task automatic hs_xfer(input logic wr, input logic t, input logic ok);
    int n;
    @(negedge mclk);
    h_try = t;
    h_put_req = wr;
    h_get_req = !wr;
    @(negedge mclk);
    h_put_req = 1'h0;
    h_get_req = 1'h0;
    n = 0;
    while ((wr ? h_put_done : h_get_done) !== 1'h1 && n < 99)
    begin
      @(negedge mclk);
      n++;
    end
    chk_bit("hs_done", 1'h1, wr ? h_put_done : h_get_done);
    chk_bit("hs_ok", ok, wr ? h_put_ok : h_get_ok);
  endtask

  task automatic hs_pull(input logic [31:0] d);
    @(negedge mclk);
    chk_bit("hs_get_valid", 1'h1, h_get_valid);
    chk_word("hs_get_data", d, h_get_data);
    h_get_ready = 1'h1;
    @(negedge mclk);
    h_get_ready = 1'h0;
  endtask

  task automatic pull(input logic [31:0] d);
    int n;
    @(negedge mclk);
    n = 0;
    while (get_valid !== 1'h1 && n < 99)
    begin
      @(negedge mclk);
      n++;
    end
    chk_bit("get_valid", 1'h1, get_valid);
    chk_word("get_data", d, get_data);
    get_ready = 1'h1;
    @(negedge mclk);
    get_ready = 1'h0;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      finish_test();
    end
  end

  initial
  begin
    lnk2.wr_en = 1'h0;
    lnk2.rd_en = 1'h0;
    lnk2.wr_data = 32'h0;
    repeat (12) @(negedge mclk);
    rst = 1'h0;
    repeat (3) @(negedge mclk);
    chk_bit("chan_empty", 1'h1, chan_empty);
    chk_bit("chan_full", 1'h0, chan_full);
    xfer(1'h1, 1'h0, 32'hA1, 1'h1);
    xfer(1'h1, 1'h0, 32'hA2, 1'h1);
    chk_bit("chan_full", 1'h1, chan_full);
    chk_word("fill_level", 32'h2, 32'(fill_level));
    xfer(1'h1, 1'h1, 32'hEE, 1'h0);
    chk_word("fill_level", 32'h2, 32'(fill_level));
    fork
      xfer(1'h1, 1'h0, 32'hA3, 1'h1);
      begin
        repeat (10) @(negedge mclk);
        chk_bit("put_busy", 1'h1, put_busy);
        xfer(1'h0, 1'h0, 32'h0, 1'h1);
      end
    join
    xfer(1'h0, 1'h0, 32'h0, 1'h1);
    xfer(1'h0, 1'h1, 32'h0, 1'h0);
    pull(32'hA1);
    pull(32'hA2);
    xfer(1'h0, 1'h1, 32'h0, 1'h1);
    pull(32'hA3);
    chk_bit("chan_empty", 1'h1, chan_empty);
    xfer(1'h0, 1'h1, 32'h0, 1'h0);
    fork
      xfer(1'h0, 1'h0, 32'h0, 1'h1);
      begin
        repeat (10) @(negedge mclk);
        chk_bit("get_busy", 1'h1, get_busy);
        xfer(1'h1, 1'h1, 32'hA4, 1'h1);
      end
    join
    pull(32'hA4);
    // Held strobes: first one lands, the second meets a closed flag
    lnk2.wr_data = 32'h5A5A0001;
    lnk2.wr_en = 1'h1;
    @(negedge mclk);
    chk_bit("wr_ack", 1'h1, lnk2.wr_ack);
    @(negedge mclk);
    chk_bit("wr_refused", 1'h1, wr_refused2);
    chk_bit("wr_ack", 1'h0, lnk2.wr_ack);
    lnk2.wr_en = 1'h0;
    chk_word("rd_data", 32'h5A5A0001, lnk2.rd_data);
    lnk2.rd_en = 1'h1;
    @(negedge mclk);
    chk_bit("rd_ack", 1'h1, lnk2.rd_ack);
    @(negedge mclk);
    chk_bit("rd_refused", 1'h1, rd_refused2);
    lnk2.rd_en = 1'h0;
    // Stream-resource user refuses a try write although its channel is empty
    h_try = 1'h1;
    a_req = 1'h1;
    @(negedge mclk);
    a_req = 1'h0;
    chk_bit("ax_put_done", 1'h1, a_put_done);
    chk_bit("ax_put_ok", 1'h0, a_put_ok);
    chk_bit("ax_get_done", 1'h1, a_get_done);
    chk_bit("ax_get_ok", 1'h0, a_get_ok);
    // Handshake pair: no try accesses, blocking write stalls with request held
    hs_xfer(1'h1, 1'h1, 1'h0);
    hs_xfer(1'h0, 1'h1, 1'h0);
    put_data = 32'hB1;
    hs_xfer(1'h1, 1'h0, 1'h1);
    put_data = 32'hB2;
    fork
      hs_xfer(1'h1, 1'h0, 1'h1);
      begin
        repeat (10) @(negedge mclk);
        chk_bit("hs_put_busy", 1'h1, h_put_busy);
        chk_bit("hs_wr_en", 1'h1, lnk3.wr_en);
        chk_bit("hs_chan_full", 1'h0, h_chan_full);
        hs_xfer(1'h0, 1'h0, 1'h1);
      end
    join
    hs_pull(32'hB1);
    hs_xfer(1'h0, 1'h0, 1'h1);
    hs_pull(32'hB2);
    chk_bit("hs_chan_empty", 1'h0, h_chan_empty);
    finish_test();
  end
endmodule
